// File: hw/alarm_if.sv
// guard and clamp alarm signals between top and alarm collector
`timescale 1ns/100ps
interface alarm_if;
  pmu_alarm_pkg::chan_vec_t guard_fault;
  pmu_alarm_pkg::chan_vec_t clamp_fault;
  logic                     clear;
  logic                     cg_enable;
  logic                     cg_latch_mode;
  logic                     guard_en;
  logic                     clamp_en;
  pmu_alarm_pkg::chan_vec_t guard_latched;
  pmu_alarm_pkg::chan_vec_t guard_live;
  pmu_alarm_pkg::chan_vec_t clamp_latched;
  pmu_alarm_pkg::chan_vec_t clamp_live;
  logic                     pin_drive;

  modport top (
    output guard_fault, clamp_fault, clear, cg_enable, cg_latch_mode,
    output guard_en, clamp_en,
    input  guard_latched, guard_live, clamp_latched, clamp_live, pin_drive
  );
  modport collector (
    input  guard_fault, clamp_fault, clear, cg_enable, cg_latch_mode,
    input  guard_en, clamp_en,
    output guard_latched, guard_live, clamp_latched, clamp_live, pin_drive
  );
endinterface

// File: hw/guard_clamp_alarm.sv
// guard and clamp alarm flags and the shared alarm pin drive
`timescale 1ns/100ps
`include "pmu_alarm_defs.svh"
module guard_clamp_alarm (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  alarm_if.collector a
);
  pmu_alarm_pkg::chan_vec_t guard_lat_q, guard_lat_d;
  pmu_alarm_pkg::chan_vec_t clamp_lat_q, clamp_lat_d;
  pmu_alarm_pkg::chan_vec_t guard_live_q, clamp_live_q;
  logic                     pin_q, pin_d;
  logic                     live_any, lat_any;
  logic                     armed_q;

  // set beats a clear arriving in the same cycle
  assign guard_lat_d = a.guard_fault | (guard_lat_q & ~{`NCH{a.clear}});
  assign clamp_lat_d = a.clamp_fault | (clamp_lat_q & ~{`NCH{a.clear}});
  assign live_any = (a.guard_en & (|guard_live_q))
                  | (a.clamp_en & (|clamp_live_q));
  assign lat_any  = (a.guard_en & (|guard_lat_q))
                  | (a.clamp_en & (|clamp_lat_q));
  assign pin_d = a.cg_enable & (a.cg_latch_mode ? lat_any : live_any);

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      guard_lat_q  <= 4'h0;
      clamp_lat_q  <= 4'h0;
      guard_live_q <= 4'h0;
      clamp_live_q <= 4'h0;
      pin_q        <= 1'b0;
    end else begin
      guard_lat_q  <= guard_lat_d;
      clamp_lat_q  <= clamp_lat_d;
      guard_live_q <= a.guard_fault;
      clamp_live_q <= a.clamp_fault;
      pin_q        <= pin_d;
    end
  end

  assign a.guard_latched = guard_lat_q;
  assign a.clamp_latched = clamp_lat_q;
  assign a.guard_live    = guard_live_q;
  assign a.clamp_live    = clamp_live_q;
  assign a.pin_drive     = pin_q;

  // checks skip the release edge, whose update still applies reset
  always_ff @(posedge i_clk) begin
    armed_q <= i_rstn;
  end

  a_latch_holds: assert property (@(posedge i_clk)
    disable iff (!i_rstn || !armed_q)
    (guard_lat_q[0] && !a.clear) |=> guard_lat_q[0])
    else $error("guard latched flag dropped without clear");
  a_latch_sets: assert property (@(posedge i_clk)
    disable iff (!i_rstn || !armed_q)
    a.clamp_fault[3] |=> clamp_lat_q[3] && clamp_live_q[3])
    else $error("clamp fault not recorded");
endmodule // guard_clamp_alarm

// File: hw/pmu_alarm_and_mode_pins.sv
// alarm pins, alarm status word, host mode select and low-sense routing
`timescale 1ns/100ps
`include "pmu_alarm_defs.svh"
module pmu_alarm_and_mode_pins (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic [`TEMP_W-1:0]   i_junction_temp,
  input  wire logic [`TEMP_W-1:0]   i_user_temp_limit,
  input  wire logic                 i_user_limit_en,
  input  wire logic                 i_meas_reg_wr,
  input  wire logic [`MEAS_W-1:0]   i_meas_reg_wdata,
  input  wire logic [`NCH-1:0]      i_guard_fault,
  input  wire logic [`NCH-1:0]      i_clamp_fault,
  input  wire logic                 i_cg_alarm_en,
  input  wire logic                 i_cg_latch_mode,
  input  wire logic                 i_guard_alarm_en,
  input  wire logic                 i_clamp_alarm_en,
  input  wire logic                 i_interface_select,
  input  wire logic [`NCH-1:0]      i_per_channel_low_sense,
  input  wire logic                 i_over_temperature_alarm_in,
  input  wire logic                 i_guard_clamp_alarm_in,
  output logic                      o_over_temperature_alarm_out,
  output logic                      o_over_temperature_alarm_oe,
  output logic                      o_guard_clamp_alarm_out,
  output logic                      o_guard_clamp_alarm_oe,
  output logic [`STATUS_W-1:0]      o_alarm_status,
  output pmu_alarm_pkg::host_mode_t o_host_mode,
  output logic                      o_comparator_pins_differential,
  output logic [`NCH-1:0]           o_low_sense_from_guard_pin,
  output logic [`NCH-1:0]           o_guard_amp_from_high_sense
);

  function automatic int status_bit(input int ch, input int field);
    status_bit = `ST_CH_BASE + ch * `ST_CH_STRIDE + field;
  endfunction

  alarm_if cg ();

  logic [`TEMP_W-1:0]        temp_limit;
  logic                      over_temp;
  logic                      clear_wr;
  logic                      temp_lat_q, temp_lat_d;
  logic                      diff_sel;
  pmu_alarm_pkg::host_mode_t mode_q, mode_d;
  logic [`NCH-1:0]           route_q;
  logic [`STATUS_W-1:0]      status_q, status_d;

  assign temp_limit = i_user_limit_en ? i_user_temp_limit
                                      : `TEMP_DEFAULT_C;
  assign over_temp  = i_junction_temp > temp_limit;
  // any channel's measurement register carries the same clear bit
  assign clear_wr   = i_meas_reg_wr & i_meas_reg_wdata[`CLEAR_BIT];
  // a fresh over-temperature beats a clear in the same cycle
  assign temp_lat_d = over_temp | (temp_lat_q & ~clear_wr);

  // the pad pull-down makes a floating select read low
  assign diff_sel = i_interface_select;
  assign mode_d   = diff_sel ? pmu_alarm_pkg::HOST_DIFFERENTIAL
                             : pmu_alarm_pkg::HOST_SERIAL;

  assign cg.guard_fault   = i_guard_fault;
  assign cg.clamp_fault   = i_clamp_fault;
  // one clear write releases temperature and guard/clamp latches
  assign cg.clear         = clear_wr;
  assign cg.cg_enable     = i_cg_alarm_en;
  assign cg.cg_latch_mode = i_cg_latch_mode;
  assign cg.guard_en      = i_guard_alarm_en;
  assign cg.clamp_en      = i_clamp_alarm_en;

  guard_clamp_alarm u_cg (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .a      (cg.collector)
  );

  always_comb begin
    status_d = '0;
    status_d[`ST_TEMP_LATCHED] = temp_lat_d;
    status_d[`ST_TEMP_LIVE]    = over_temp;
    for (int ch = 0; ch < `NCH; ch++) begin
      status_d[status_bit(ch, `ST_GUARD_LATCHED)] = cg.guard_latched[ch];
      status_d[status_bit(ch, `ST_GUARD_LIVE)]    = cg.guard_live[ch];
      status_d[status_bit(ch, `ST_CLAMP_LATCHED)] = cg.clamp_latched[ch];
      status_d[status_bit(ch, `ST_CLAMP_LIVE)]    = cg.clamp_live[ch];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      temp_lat_q  <= 1'b0;
      mode_q      <= pmu_alarm_pkg::HOST_SERIAL;
      route_q     <= 4'h0;
      status_q    <= '0;
    end else begin
      temp_lat_q  <= temp_lat_d;
      mode_q      <= mode_d;
      route_q     <= i_per_channel_low_sense;
      status_q    <= status_d;
    end
  end

  // open-drain pads: output level is always low, enable pulls the line
  assign o_over_temperature_alarm_out   = 1'b0;
  assign o_over_temperature_alarm_oe    = temp_lat_q;
  assign o_guard_clamp_alarm_out        = 1'b0;
  assign o_guard_clamp_alarm_oe         = cg.pin_drive;
  assign o_alarm_status                 = status_q;
  assign o_host_mode                    = mode_q;
  assign o_comparator_pins_differential =
    (mode_q == pmu_alarm_pkg::HOST_DIFFERENTIAL);
  assign o_low_sense_from_guard_pin     = route_q;
  // guard input moves to high sense when its pin becomes low sense
  assign o_guard_amp_from_high_sense    = route_q;

  // checks skip the release edge, whose update still applies reset
  logic armed_q;
  always_ff @(posedge i_clk) begin
    armed_q <= i_rstn;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn || !armed_q);

  a_reset_quiet: assert property (disable iff (1'b0)
    !i_rstn |=> (!o_over_temperature_alarm_oe && !o_guard_clamp_alarm_oe
                 && o_alarm_status == '0
                 && o_host_mode == pmu_alarm_pkg::HOST_SERIAL))
    else $error("state not at defaults after reset");
  a_temp_alarm_set: assert property (
    over_temp |=> o_over_temperature_alarm_oe
                  && o_alarm_status[`ST_TEMP_LATCHED])
    else $error("over temperature not flagged");
  a_temp_alarm_hold: assert property (
    (o_over_temperature_alarm_oe && !clear_wr)
      |=> o_over_temperature_alarm_oe)
    else $error("temperature alarm released without clear");
  a_temp_clear_works: assert property (
    (clear_wr && !over_temp) |=> !o_over_temperature_alarm_oe)
    else $error("clear did not release temperature alarm");
  a_temp_live_flag: assert property (
    ##1 o_alarm_status[`ST_TEMP_LIVE] == $past(over_temp))
    else $error("live temperature flag wrong");
  a_cg_disabled: assert property (
    (!i_cg_alarm_en ##1 !i_cg_alarm_en) |=> !o_guard_clamp_alarm_oe)
    else $error("guard/clamp pin active while disabled");
  a_cg_live_path: assert property (
    (i_cg_alarm_en && !i_cg_latch_mode && i_guard_alarm_en
      && !i_clamp_alarm_en)[*2] ##0 $past(i_guard_fault) == 4'h0
      |=> !o_guard_clamp_alarm_oe)
    else $error("live mode pin kept stale alarm");
  a_cg_guard_drives: assert property (
    (i_guard_fault[1] && i_guard_alarm_en) ##1
      (i_cg_alarm_en && i_guard_alarm_en && !i_cg_latch_mode)
      |=> o_guard_clamp_alarm_oe)
    else $error("guard fault did not reach pin");
  a_cg_source_masked: assert property (
    (!i_guard_alarm_en && !i_clamp_alarm_en)[*2] |=> !o_guard_clamp_alarm_oe)
    else $error("pin active with both sources masked");
  a_cg_latched_hold: assert property (
    (o_guard_clamp_alarm_oe && i_cg_alarm_en && i_cg_latch_mode
      && i_guard_alarm_en && !i_clamp_alarm_en && !clear_wr)[*2]
      |=> o_guard_clamp_alarm_oe)
    else $error("latched guard/clamp alarm dropped");
  a_ch_status_flags: assert property (
    i_clamp_fault[2] |=> ##1 o_alarm_status[status_bit(2, `ST_CLAMP_LIVE)])
    else $error("channel clamp flag missing");
  a_mode_select: assert property (
    i_interface_select |=> o_host_mode == pmu_alarm_pkg::HOST_DIFFERENTIAL)
    else $error("select high did not pick differential");
  a_mode_serial: assert property (
    !i_interface_select |=> o_host_mode == pmu_alarm_pkg::HOST_SERIAL)
    else $error("select low did not pick serial");
  a_cmp_pins_role: assert property (
    $rose(i_interface_select) |=> o_comparator_pins_differential)
    else $error("comparator pins not differential");
  a_low_sense_route: assert property (
    i_per_channel_low_sense[3] |=> o_low_sense_from_guard_pin[3]
                                   && o_guard_amp_from_high_sense[3])
    else $error("low-sense routing not applied");
  a_default_route: assert property (
    !i_per_channel_low_sense[0] |=> !o_guard_amp_from_high_sense[0])
    else $error("guard input moved off its pin");
  a_temp_quiet: assert property (
    (!i_user_limit_en && (i_junction_temp <= `TEMP_DEFAULT_C)
      && !o_over_temperature_alarm_oe) |=> !o_over_temperature_alarm_oe)
    else $error("temperature alarm raised at or below default limit");
  a_user_limit: assert property (
    (i_user_limit_en && (i_junction_temp > i_user_temp_limit))
      |=> o_over_temperature_alarm_oe)
    else $error("user temperature limit ignored");
  a_cg_clear_works: assert property (
    (clear_wr && (i_guard_fault == 4'h0) && (i_clamp_fault == 4'h0))
      |=> (cg.guard_latched == 4'h0) && (cg.clamp_latched == 4'h0))
    else $error("clear did not release guard/clamp flags");
  a_cg_clamp_drives: assert property (
    (i_clamp_fault[2] && i_clamp_alarm_en) ##1
      (i_cg_alarm_en && i_clamp_alarm_en && !i_cg_latch_mode)
      |=> o_guard_clamp_alarm_oe)
    else $error("clamp fault did not reach pin");
  a_cg_clamp_latched: assert property (
    (o_guard_clamp_alarm_oe && i_cg_alarm_en && i_cg_latch_mode
      && i_clamp_alarm_en && !i_guard_alarm_en && !clear_wr)[*2]
      |=> o_guard_clamp_alarm_oe)
    else $error("latched clamp alarm dropped");
  a_cmp_pins_serial: assert property (
    !i_interface_select |=> !o_comparator_pins_differential)
    else $error("comparator pins differential in serial mode");

  c_temp_alarm_cleared: cover property (
    o_over_temperature_alarm_oe ##1 !o_over_temperature_alarm_oe);
  c_cg_latched_alarm: cover property (
    i_cg_latch_mode && o_guard_clamp_alarm_oe);
  c_differential_mode: cover property (o_comparator_pins_differential);
  c_set_with_clear: cover property (over_temp && clear_wr);
  c_pads_pulled: cover property (
    !i_over_temperature_alarm_in && !i_guard_clamp_alarm_in);

endmodule // pmu_alarm_and_mode_pins

// File: hw/pmu_alarm_defs.svh
// constants for the alarm, mode and pin routing block
`ifndef PMU_ALARM_DEFS_SVH
`define PMU_ALARM_DEFS_SVH

`define NCH              4
`define TEMP_W           8
`define TEMP_DEFAULT_C   8'h82
`define MEAS_W           16
`define CLEAR_BIT        6
`define STATUS_W         18
`define ST_TEMP_LATCHED  0
`define ST_TEMP_LIVE     1
`define ST_CH_BASE       2
`define ST_CH_STRIDE     4
`define ST_GUARD_LATCHED 0
`define ST_GUARD_LIVE    1
`define ST_CLAMP_LATCHED 2
`define ST_CLAMP_LIVE    3

`endif

// File: hw/pmu_alarm_pkg.sv
// types shared by the alarm, mode and pin routing block
package pmu_alarm_pkg;

  typedef enum logic [1:0] {
    HOST_SERIAL       = 2'h1,
    HOST_DIFFERENTIAL = 2'h2
  } host_mode_t;

  typedef logic [3:0] chan_vec_t;

endpackage

// File: test/host_model.sv
// host controller model: alarm pull-ups, select pull-down, clear writes
`timescale 1ns/100ps
module host_model (
  input  wire logic        i_clk,
  input  wire logic        i_temp_oe,
  input  wire logic        i_cg_oe,
  input  wire logic        i_sel_drive,
  input  wire logic        i_sel_float,
  output logic             o_temp_pin,
  output logic             o_cg_pin,
  output logic             o_select,
  output logic             o_wr,
  output logic [15:0]      o_wdata
);
  // open-drain pins rest high on the board pull-ups
  assign o_temp_pin = i_temp_oe ? 1'h0 : 1'h1;
  assign o_cg_pin   = i_cg_oe ? 1'h0 : 1'h1;
  // an unconnected select pin is held low by the pull-down
  assign o_select   = i_sel_float ? 1'h0 : i_sel_drive;

  initial begin
    o_wr    = 1'h0;
    o_wdata = 16'h0000;
  end

  // one-cycle measurement register write; data inverted once released
  task automatic write_meas(input logic [15:0] d);
    @(posedge i_clk);
    o_wr    <= 1'h1;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr    <= 1'h0;
    o_wdata <= ~d;
  endtask
endmodule // host_model

// File: test/pmu_alarm_and_mode_pins_bench.sv
// self-checking bench for the alarm, mode and pin routing block
`timescale 1ns/100ps
module pmu_alarm_and_mode_pins_bench;
  typedef struct {
    logic [7:0]  t, lim;
    logic        ue, en, ge, ce, sel;
    logic [3:0]  g, c, pl;
    logic        ot, cg;
    logic [17:0] st;
  } row_t;
  localparam pmu_alarm_pkg::host_mode_t SER  = pmu_alarm_pkg::HOST_SERIAL;
  localparam pmu_alarm_pkg::host_mode_t DIFF =
    pmu_alarm_pkg::HOST_DIFFERENTIAL;
  logic                      i_clk     = 1'h0;
  logic                      i_rstn    = 1'h0;
  logic                      latch     = 1'h0;
  logic                      sel_float = 1'h0;
  row_t                      cur       = '{default: '0};
  row_t                      rows [5];
  wire logic                 temp_pin, cg_pin, select, wr;
  wire logic [15:0]          wdata;
  logic                      ot_oe, cg_oe, diff, ot_lvl, cg_lvl;
  logic [17:0]               st;
  logic [3:0]                lsr, gar;
  pmu_alarm_pkg::host_mode_t mode;
  int                        errors   = 0;
  int                        compares = 0;

  host_model host (.i_clk(i_clk), .i_temp_oe(ot_oe), .i_cg_oe(cg_oe),
    .i_sel_drive(cur.sel), .i_sel_float(sel_float), .o_temp_pin(temp_pin),
    .o_cg_pin(cg_pin), .o_select(select), .o_wr(wr), .o_wdata(wdata));

  pmu_alarm_and_mode_pins DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_junction_temp(cur.t), .i_user_temp_limit(cur.lim),
    .i_user_limit_en(cur.ue), .i_meas_reg_wr(wr), .i_meas_reg_wdata(wdata),
    .i_guard_fault(cur.g), .i_clamp_fault(cur.c), .i_cg_alarm_en(cur.en),
    .i_cg_latch_mode(latch), .i_guard_alarm_en(cur.ge),
    .i_clamp_alarm_en(cur.ce), .i_interface_select(select),
    .i_per_channel_low_sense(cur.pl),
    .i_over_temperature_alarm_in(temp_pin),
    .i_guard_clamp_alarm_in(cg_pin), .o_over_temperature_alarm_out(ot_lvl),
    .o_over_temperature_alarm_oe(ot_oe), .o_guard_clamp_alarm_out(cg_lvl),
    .o_guard_clamp_alarm_oe(cg_oe), .o_alarm_status(st), .o_host_mode(mode),
    .o_comparator_pins_differential(diff),
    .o_low_sense_from_guard_pin(lsr), .o_guard_amp_from_high_sense(gar));

  initial begin
    forever #10 i_clk = ~i_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [17:0] e,
                     input logic [17:0] v);
    compares++;
    if (v !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask

  task automatic clear_all();
    @(posedge i_clk);
    cur <= rows[0];
    host.write_meas(16'h0040);
    tick(2);
  endtask

  task automatic end_sim();
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #60000;
    errors++;
    end_sim();
  end

  initial begin
    rows = '{
      '{8'h82,8'h00,1'h0,1'h0,1'h0,1'h0,1'h0,4'h0,4'h0,4'h0,1'h0,1'h0,18'h00000},
      '{8'h83,8'h00,1'h0,1'h1,1'h1,1'h0,1'h1,4'h2,4'h0,4'h5,1'h1,1'h1,18'h000C3},
      '{8'h50,8'h4F,1'h1,1'h1,1'h1,1'h0,1'h0,4'h0,4'h8,4'hA,1'h1,1'h0,18'h30003},
      '{8'h90,8'hA0,1'h1,1'h0,1'h1,1'h1,1'h1,4'h1,4'h1,4'hF,1'h0,1'h0,18'h0003C},
      '{8'h00,8'h00,1'h0,1'h1,1'h0,1'h1,1'h0,4'h0,4'h4,4'h0,1'h0,1'h1,18'h03000}};
    tick(5);
    chk("reset status", 18'h00000, st);
    chk("reset mode", SER, mode);
    chk("reset cg oe", 1'h0, cg_oe);
    @(posedge i_clk);
    i_rstn <= 1'h1;
    foreach (rows[i]) begin
      @(posedge i_clk);
      cur <= rows[i];
      tick(3);
      chk("temp oe", rows[i].ot, ot_oe);
      chk("cg oe", rows[i].cg, cg_oe);
      chk("status", rows[i].st, st);
      chk("mode", rows[i].sel ? DIFF : SER, mode);
      chk("comp diff", rows[i].sel, diff);
      chk("low sense", rows[i].pl, lsr);
      chk("guard route", rows[i].pl, gar);
      chk("temp level", 1'h0, ot_lvl);
      chk("cg level", 1'h0, cg_lvl);
      clear_all();
      chk("cleared", 18'h00000, st);
      chk("cleared oe", 1'h0, ot_oe);
    end
    // one-cycle excursion must stay latched after the drop
    @(posedge i_clk);
    cur.t <= 8'h83;
    @(posedge i_clk);
    cur.t <= 8'h00;
    tick(3);
    chk("temp latched", 18'h00001, st);
    chk("temp pin", 1'h0, temp_pin);
    host.write_meas(16'hFFBF);
    tick(2);
    chk("no clear bit", 1'h1, ot_oe);
    @(posedge i_clk);
    cur.t <= 8'hFF;
    host.write_meas(16'h0040);
    tick(2);
    chk("set wins", 1'h1, ot_oe);
    clear_all();
    chk("temp pin free", 1'h1, temp_pin);
    // latched pin mode keeps a clamp pulse
    @(posedge i_clk);
    cur <= rows[4];
    latch <= 1'h1;
    @(posedge i_clk);
    cur.c <= 4'h0;
    tick(3);
    chk("cg flags", 18'h01000, st);
    chk("cg held", 1'h0, cg_pin);
    @(posedge i_clk);
    latch <= 1'h0;
    tick(2);
    chk("cg live", 1'h1, cg_pin);
    // latched guard source held until the clear write
    @(posedge i_clk);
    cur <= rows[1];
    latch <= 1'h1;
    @(posedge i_clk);
    cur.g <= 4'h0;
    cur.t <= 8'h00;
    tick(3);
    chk("guard held", 1'h0, cg_pin);
    host.write_meas(16'h0040);
    tick(2);
    chk("guard released", 1'h1, cg_pin);
    chk("temp cleared", 1'h0, ot_oe);
    @(posedge i_clk);
    i_rstn <= 1'h0;
    tick(1);
    chk("mid reset", 18'h00000, st);
    @(posedge i_clk);
    i_rstn <= 1'h1;
    cur.sel <= 1'h1;
    tick(2);
    chk("mode after reset", DIFF, mode);
    @(posedge i_clk);
    sel_float <= 1'h1;
    tick(2);
    chk("float select", SER, mode);
    end_sim();
  end
endmodule // pmu_alarm_and_mode_pins_bench
